// ===== pkg/ebc_map.svh
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH
// ----------------------------------------
// bus geometry
// ----------------------------------------
`define EBC_NUM_CS 4
`define EBC_CS_W 2
`define EBC_ADDR_W 24
`define EBC_DATA_W 16
`define EBC_CNT_W 6
`define EBC_PH_W 7
// ----------------------------------------
// timing: one phase time unit at the system clock
// ----------------------------------------
`define EBC_SYS_CLK_MHZ 40
`define EBC_PHASE_UNIT_NS 25
`define EBC_PHASE_UNIT_CYC ((`EBC_PHASE_UNIT_NS * `EBC_SYS_CLK_MHZ) / 1000)
// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define EBC_AXI_AW 8
`define EBC_OFS_TCFG0 8'h00
`define EBC_TCFG_STRIDE 8'h04
`define EBC_OFS_CTRL 8'h10
`define EBC_OFS_STAT 8'h14
`define EBC_TCFG_RST 32'h00000000
`define EBC_CTRL_RST 32'h00000001
`define EBC_RESP_OKAY 2'h0
`define EBC_RESP_SLVERR 2'h2
// ----------------------------------------
// chip_select_timing_config fields, then the control word clock enable bit
// ----------------------------------------
`define EBC_F_AB 0
`define EBC_F_ABX 1
`define EBC_F_C 3
`define EBC_F_D 5
`define EBC_F_E 6
`define EBC_F_F 11
`define EBC_F_REN 13
`define EBC_F_RPOL 14
`define EBC_F_RASY 15
`define EBC_F_CLKEN 0
`endif

// ===== pkg/ebc_pkg.sv
`default_nettype none
`include "ebc_map.svh"
package ebc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_AB, ST_C, ST_D, ST_E, ST_F} ebc_phase_t;
  typedef struct packed {
    logic ab;         // 0: one unit, 1: two units
    logic [1:0] abx;  // extra units on window change
    logic [1:0] c;
    logic d;
    logic [4:0] e;    // length minus one
    logic [1:0] f;
    logic ren;
    logic rpol;       // 1: ready active high
    logic rasy;
  } ebc_tcfg_t;

  // register word to timing fields
  function automatic ebc_tcfg_t ebc_decode(input logic [31:0] w);
    ebc_tcfg_t t;
    t.ab = w[`EBC_F_AB];
    t.abx = w[`EBC_F_ABX +: 2];
    t.c = w[`EBC_F_C +: 2];
    t.d = w[`EBC_F_D];
    t.e = w[`EBC_F_E +: 5];
    t.f = w[`EBC_F_F +: 2];
    t.ren = w[`EBC_F_REN];
    t.rpol = w[`EBC_F_RPOL];
    t.rasy = w[`EBC_F_RASY];
    return t;
  endfunction
endpackage
`default_nettype wire

// ===== pkg/ebc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"
interface ebc_cfg_if;
  import ebc_pkg::*;
  ebc_tcfg_t tcfg [`EBC_NUM_CS];
  logic clkOutEn;
  logic busy;
  logic [`EBC_CS_W-1:0] curCs;
  modport regs (output tcfg, output clkOutEn, input busy, input curCs);
  modport core (input tcfg, input clkOutEn, output busy, output curCs);
endinterface
`default_nettype wire

// ===== core/ebc_axi_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"
module ebc_axi_regs
  import ebc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [`EBC_AXI_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`EBC_AXI_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // towards the sequencer
  ebc_cfg_if.regs cfg
);
  logic [31:0] tcfgReg [`EBC_NUM_CS];
  logic [31:0] ctrlReg;
  logic awHeld, wHeld, doWr;
  logic [`EBC_AXI_AW-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;

  function automatic logic isMapped(input logic [`EBC_AXI_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a < `EBC_OFS_CTRL || a == `EBC_OFS_CTRL || a == `EBC_OFS_STAT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  // address and data taken in either order, response after both
  assign awready = ce && !awHeld && !bvalid;
  assign wready = ce && !wHeld && !bvalid;
  assign arready = ce && !rvalid;
  assign doWr = ce && awHeld && wHeld && !bvalid;

  // -------------------------------------
  // write channel
  // -------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= '0;
      bvalid <= 1'b0;
      bresp <= `EBC_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWr) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= isMapped(awAddrQ) ? `EBC_RESP_OKAY : `EBC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------
  // one timing word per chip select
  // -------------------------------------
  for (genvar i = 0; i < `EBC_NUM_CS; i++) begin : g_tcfg
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        tcfgReg[i] <= `EBC_TCFG_RST;
      end else if (ce && doWr &&
                   awAddrQ == `EBC_OFS_TCFG0 + `EBC_AXI_AW'(i) * `EBC_TCFG_STRIDE) begin
        tcfgReg[i] <= merge(tcfgReg[i], wDataQ, wStrbQ);
      end
    end
    assign cfg.tcfg[i] = ebc_decode(tcfgReg[i]);
  end

  // control word, clock output enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrlReg <= `EBC_CTRL_RST;
    end else if (ce && doWr && awAddrQ == `EBC_OFS_CTRL) begin
      ctrlReg <= merge(ctrlReg, wDataQ, wStrbQ);
    end
  end
  assign cfg.clkOutEn = ctrlReg[`EBC_F_CLKEN];

  // -------------------------------------
  // read channel, answer one cycle after address
  // -------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `EBC_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= isMapped(araddr) ? `EBC_RESP_OKAY : `EBC_RESP_SLVERR;
        if (araddr == `EBC_OFS_CTRL) rdata <= ctrlReg;
        else if (araddr == `EBC_OFS_STAT) rdata <= {29'h0, cfg.curCs, cfg.busy};
        else if (isMapped(araddr)) rdata <= tcfgReg[araddr[3:2]];
        else rdata <= '0;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/ebc_bus_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"
module ebc_bus_sequencer
  import ebc_pkg::*;
(
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // access request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [`EBC_CS_W-1:0] reqCs,
  input wire logic [`EBC_ADDR_W-1:0] reqAddr,
  input wire logic [`EBC_DATA_W-1:0] reqWdata,
  output logic rspValid,
  output logic [`EBC_DATA_W-1:0] rspRdata,
  // axi4-lite register port
  input wire logic awvalid,
  output logic awready,
  input wire logic [`EBC_AXI_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`EBC_AXI_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // external bus pins
  output logic [`EBC_ADDR_W-1:0] busAddr,
  output logic [`EBC_NUM_CS-1:0] busCs_n,
  output logic busAle,
  output logic busRd_n,
  output logic busWr_n,
  output logic [`EBC_DATA_W-1:0] busDataOut,
  output logic busDataOe,
  input wire logic [`EBC_DATA_W-1:0] busDataIn,
  input wire logic busReadyIn,
  output logic busReferenceClockOut
);
  ebc_cfg_if cfg ();
  ebc_phase_t state, next_state;
  ebc_tcfg_t curCfg, selCfg;
  logic curWrite, csChanged, anyDone, rdyActive, accessDone;
  logic [`EBC_CS_W-1:0] curCs, lastCs;
  logic [`EBC_CNT_W-1:0] cnt, next_cnt;
  logic rdy1, rdy2, rdy3, rdySample;
  logic [`EBC_DATA_W-1:0] dIn1, dIn2;
  logic [`EBC_PH_W-1:0] phCycles;
  logic [`EBC_CNT_W-1:0] abTarget;

  ebc_axi_regs u_regs (
    .clock(clock), .rst(rst), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .cfg(cfg.regs)
  );

  // --------------------------------------------
  // phase ordering and lengths
  // --------------------------------------------
  // first non-empty phase after p; empty phases are skipped
  function automatic ebc_phase_t after(input ebc_phase_t p, input ebc_tcfg_t t);
    ebc_phase_t n;
    n = ST_IDLE;
    unique case (p)
      ST_IDLE: n = ST_AB;
      ST_AB: n = (t.c != 2'h0) ? ST_C : (t.d ? ST_D : ST_E);
      ST_C: n = t.d ? ST_D : ST_E;
      ST_D: n = ST_E;
      ST_E: n = (t.f != 2'h0) ? ST_F : ST_IDLE;
      ST_F: n = ST_IDLE;
    endcase
    return n;
  endfunction

  // length in units of phase p, scaled to clock cycles
  function automatic logic [`EBC_CNT_W-1:0] units(input ebc_phase_t p, input ebc_tcfg_t t,
                                                  input logic ext);
    logic [`EBC_CNT_W-1:0] u;
    u = '0;
    unique case (p)
      ST_AB: u = `EBC_CNT_W'(t.ab) + `EBC_CNT_W'(1) + (ext ? `EBC_CNT_W'(t.abx) : '0);
      ST_C: u = `EBC_CNT_W'(t.c);
      ST_D: u = `EBC_CNT_W'(t.d);
      ST_E: u = `EBC_CNT_W'(t.e) + `EBC_CNT_W'(1);
      ST_F: u = `EBC_CNT_W'(t.f);
      ST_IDLE: u = '0;
    endcase
    return `EBC_CNT_W'(u * `EBC_PHASE_UNIT_CYC);
  endfunction

  // window change: other chip select than the previous access
  assign selCfg = (state == ST_IDLE) ? cfg.tcfg[reqCs] : curCfg;
  assign csChanged = (state == ST_IDLE) ? (!anyDone || reqCs != lastCs) : (curCs != lastCs);
  assign reqReady = ce && (state == ST_IDLE);

  // --------------------------------------------
  // ready synchroniser, extra stage when asynchronous
  // --------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdy1 <= 1'b0;
      rdy2 <= 1'b0;
      rdy3 <= 1'b0;
      dIn1 <= '0;
      dIn2 <= '0;
    end else if (ce) begin
      rdy1 <= busReadyIn;
      rdy2 <= rdy1;
      rdy3 <= rdy2;
      dIn1 <= busDataIn;
      dIn2 <= dIn1;
    end
  end
  assign rdySample = curCfg.rasy ? rdy3 : rdy2;
  assign rdyActive = (rdySample == curCfg.rpol);
  // inactive sample holds access one more cycle, active ends it
  assign accessDone = (cnt == '0) && (!curCfg.ren || rdyActive);

  // --------------------------------------------
  // next phase
  // --------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = (cnt != '0) ? cnt - `EBC_CNT_W'(1) : cnt;
    unique case (state)
      ST_IDLE: if (reqValid) next_state = ST_AB;
      ST_AB, ST_C, ST_D, ST_F: if (cnt == '0) next_state = after(state, selCfg);
      ST_E: if (accessDone) next_state = after(state, selCfg);
    endcase
    if (next_state != state && next_state != ST_IDLE) begin
      next_cnt = units(next_state, selCfg, csChanged) - `EBC_CNT_W'(1);
    end
  end

  // sequencer state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // per-access context latched when the request is taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      curCfg <= '0;
      curCs <= '0;
      curWrite <= 1'b0;
      lastCs <= '0;
      anyDone <= 1'b0;
      abTarget <= '0;
    end else if (ce) begin
      if (state == ST_IDLE && reqValid) begin
        curCfg <= cfg.tcfg[reqCs];
        curCs <= reqCs;
        curWrite <= reqWrite;
        abTarget <= units(ST_AB, selCfg, csChanged);
      end
      if (state != ST_IDLE && next_state == ST_IDLE) begin
        lastCs <= curCs;
        anyDone <= 1'b1;
      end
    end
  end

  // --------------------------------------------
  // pins, registered from the coming phase
  // --------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busAddr <= '0;
      busDataOut <= '0;
      busCs_n <= '1;
      busAle <= 1'b0;
      busRd_n <= 1'b1;
      busWr_n <= 1'b1;
      busDataOe <= 1'b0;
    end else if (ce) begin
      if (state == ST_IDLE && reqValid) begin
        busAddr <= reqAddr;
        busDataOut <= reqWdata;
      end
      busCs_n <= '1;
      if (next_state != ST_IDLE) busCs_n[(state == ST_IDLE) ? reqCs : curCs] <= 1'b0;
      busAle <= (next_state == ST_AB);
      busRd_n <= !(next_state == ST_E && !((state == ST_IDLE) ? reqWrite : curWrite));
      busWr_n <= !(next_state == ST_E && curWrite);
      // data driven from write setup through hold; turnaround otherwise
      busDataOe <= curWrite && (next_state inside {ST_D, ST_E, ST_F});
    end
  end

  // read data captured on the edge that lifts the read strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rspRdata <= '0;
      rspValid <= 1'b0;
    end else if (ce) begin
      rspValid <= (state != ST_IDLE) && (next_state == ST_IDLE);
      if (state == ST_E && accessDone && !curWrite) rspRdata <= dIn2;
    end else begin
      rspValid <= 1'b0;
    end
  end

  // clock output follows the system clock; gate only while driver enabled
  assign busReferenceClockOut = clock & cfg.clkOutEn;
  assign cfg.busy = (state != ST_IDLE);
  assign cfg.curCs = curCs;

  // --------------------------------------------
  // checks
  // --------------------------------------------
  // cycles spent in the current phase, for the length checks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) phCycles <= '0;
    else if (ce) phCycles <= (next_state != state) ? '0 : phCycles + `EBC_PH_W'(1);
  end

  AST_ORDER: assert property (@(posedge clock) disable iff (rst)
    ce && state != ST_E && next_state == ST_E |-> state inside {ST_AB, ST_C, ST_D})
    else $error("access entered out of order");
  AST_AB_LEN: assert property (@(posedge clock) disable iff (rst)
    ce && state == ST_AB && next_state != ST_AB |-> phCycles + `EBC_PH_W'(1) == `EBC_PH_W'(abTarget))
    else $error("address setup length wrong");
  AST_C_LEN: assert property (@(posedge clock) disable iff (rst)
    ce && state == ST_C && next_state != ST_C |-> phCycles + `EBC_PH_W'(1) == `EBC_PH_W'(curCfg.c))
    else $error("command delay length wrong");
  AST_D_LEN: assert property (@(posedge clock) disable iff (rst)
    ce && state == ST_D && next_state != ST_D |-> phCycles == '0 && curCfg.d)
    else $error("write setup length wrong");
  AST_F_LEN: assert property (@(posedge clock) disable iff (rst)
    ce && state == ST_F && next_state != ST_F |-> phCycles + `EBC_PH_W'(1) == `EBC_PH_W'(curCfg.f))
    else $error("hold length wrong");
  AST_E_MIN: assert property (@(posedge clock) disable iff (rst)
    ce && state == ST_E && next_state != ST_E |-> phCycles >= `EBC_PH_W'(curCfg.e))
    else $error("access phase too short");
  AST_RDY_WAIT: assert property (@(posedge clock) disable iff (rst)
    ce && state == ST_E && cnt == '0 && curCfg.ren && rdySample != curCfg.rpol
    |=> state == ST_E && !busRd_n == !curWrite)
    else $error("wait state not inserted");
  AST_RDY_END: assert property (@(posedge clock) disable iff (rst)
    ce && state == ST_E && cnt == '0 && curCfg.ren && rdySample == curCfg.rpol
    |=> state != ST_E && busRd_n && busWr_n)
    else $error("active ready did not end access");
  AST_RD_LATCH: assert property (@(posedge clock) disable iff (rst)
    ce && state == ST_E && next_state != ST_E && !curWrite |=> rspRdata == $past(dIn2) && busRd_n)
    else $error("read data not captured at strobe end");
endmodule
`default_nettype wire

// ===== dv/ebc_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"
// ----------------------------------------
// external memory with ready handshake
// ----------------------------------------
module ebc_ext_mem (
  // clock
  input wire logic clock,
  // bus pins from the sequencer
  input wire logic [`EBC_ADDR_W-1:0] busAddr,
  input wire logic [`EBC_NUM_CS-1:0] busCs_n,
  input wire logic busRd_n,
  input wire logic busWr_n,
  input wire logic [`EBC_DATA_W-1:0] busDataOut,
  input wire logic busDataOe,
  // answers towards the sequencer
  output logic [`EBC_DATA_W-1:0] busDataIn,
  output logic busReadyIn,
  // ready behaviour chosen by the bench
  input wire logic [3:0] rdyDelay,
  input wire logic rdyPol
);
  logic [`EBC_DATA_W-1:0] mem [16];
  logic [`EBC_DATA_W-1:0] lastData = 16'h0000;
  logic [3:0] cmdCnt = 4'h0;
  logic drive;
  logic cmdIdle;
  // a released bus shows the inverse, so a stale value never passes as data
  assign drive = ~&busCs_n & ~busDataOe;
  assign busDataIn = drive ? mem[busAddr[3:0]] : ~lastData;
  assign cmdIdle = busRd_n & busWr_n;
  // storage and the last value driven
  always @(posedge clock) begin
    if (drive) begin
      lastData <= mem[busAddr[3:0]];
    end
    if (!busWr_n) begin
      mem[busAddr[3:0]] <= busDataOut;
    end
  end
  // strobe age; ready drops as soon as the strobe ends
  always @(posedge clock) begin
    if (cmdIdle) begin
      cmdCnt <= 4'h0;
    end else if (cmdCnt != 4'hF) begin
      cmdCnt <= cmdCnt + 4'h1;
    end
  end
  assign busReadyIn = (~cmdIdle & (cmdCnt >= rdyDelay)) ? rdyPol : ~rdyPol;
endmodule
`default_nettype wire

// ===== dv/test_external_bus_cycle_phases.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"
module test_external_bus_cycle_phases;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock, rst = 1'b1, ce = 1'b1, reqReady, rspValid, busAle, busRd_n, busWr_n;
  logic reqValid = 1'b0, reqWrite = 1'b0, rdyPol = 1'b1, busDataOe, busReadyIn, bus_reference_clock_out;
  logic [`EBC_CS_W-1:0] reqCs = '0;
  logic [`EBC_ADDR_W-1:0] reqAddr = 24'h000035, busAddr;
  logic [`EBC_DATA_W-1:0] reqWdata = '0, rspRdata, busDataOut, busDataIn;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [`EBC_AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF, rdyDelay = 4'h0;
  logic [1:0] bresp, rresp;
  logic [`EBC_NUM_CS-1:0] busCs_n;
  int err_total = 0, samples_checked = 0, cycles = 0;
  int nAb, nGap, nE, nOe, nCs, nLat, eSync;

  ebc_bus_sequencer DUT (.clock(clock), .rst(rst), .ce(ce), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqCs(reqCs), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .busAddr(busAddr), .busCs_n(busCs_n), .busAle(busAle),
    .busRd_n(busRd_n), .busWr_n(busWr_n), .busDataOut(busDataOut),
    .busDataOe(busDataOe), .busDataIn(busDataIn), .busReadyIn(busReadyIn),
    .busReferenceClockOut(bus_reference_clock_out));

  ebc_ext_mem mem (.clock(clock), .busAddr(busAddr), .busCs_n(busCs_n),
    .busRd_n(busRd_n), .busWr_n(busWr_n), .busDataOut(busDataOut),
    .busDataOe(busDataOe), .busDataIn(busDataIn), .busReadyIn(busReadyIn),
    .rdyDelay(rdyDelay), .rdyPol(rdyPol));

  // 40 MHz system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // each channel drops its valid only at the edge where it was taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
    @(posedge clock);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    check(rdata, ed);
    check(rresp, er);
    @(posedge clock);
  endtask

  task automatic set_cfg(input logic [1:0] cs, input logic [31:0] w);
    axi_write(`EBC_OFS_TCFG0 + {4'h0, cs, 2'b00}, w, `EBC_RESP_OKAY);
  endtask

  // timing word; e is the access length minus one, rdy is {async, polarity, enable}
  function automatic logic [31:0] tw(input int ab, abx, c, d, e, f, rdy);
    logic [31:0] w;
    w = '0;
    w[`EBC_F_AB] = ab[0];
    w[`EBC_F_ABX +: 2] = abx[1:0];
    w[`EBC_F_C +: 2] = c[1:0];
    w[`EBC_F_D] = d[0];
    w[`EBC_F_E +: 5] = e[4:0];
    w[`EBC_F_F +: 2] = f[1:0];
    w[`EBC_F_REN +: 3] = rdy[2:0];
    return w;
  endfunction

  // one access; phase lengths counted from the pins, values seen before each edge
  task automatic access(input logic wr, input logic [1:0] cs, input logic [15:0] d);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqCs <= cs;
    reqWdata <= d;
    do @(posedge clock); while (!reqReady);
    reqValid <= 1'b0;
    nAb = 0;
    nGap = 0;
    nE = 0;
    nOe = 0;
    nCs = 0;
    nLat = 0;
    do begin
      @(posedge clock);
      nLat++;
      if (busAle) nAb++;
      if (!busRd_n || !busWr_n) nE++;
      if (!(&busCs_n) && !busAle && busRd_n && busWr_n && nE == 0) nGap++;
      if (busDataOe) nOe++;
      if (!(&busCs_n)) nCs++;
    end while (!rspValid);
    @(posedge clock);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_regs;
    axi_read(`EBC_OFS_CTRL, `EBC_CTRL_RST, `EBC_RESP_OKAY);
    axi_read(`EBC_OFS_TCFG0 + `EBC_TCFG_STRIDE, `EBC_TCFG_RST, `EBC_RESP_OKAY);
    axi_read(8'h20, 32'h0, `EBC_RESP_SLVERR);
    axi_write(8'h20, 32'hFFFF, `EBC_RESP_SLVERR);
  endtask

  task automatic s_default;
    access(1'b0, 2'd0, 16'h0);
    check(nAb, 1);
    check(nE, 1);
    check(nCs, 2);
    check(nLat, 3);
    check(busAddr, reqAddr);
  endtask

  // longest settings on every phase, write then read back on the same select
  task automatic s_phases;
    set_cfg(2'd1, tw(1, 3, 3, 1, 31, 3, 0));
    access(1'b1, 2'd1, 16'hA5C3);
    check(nAb, 5);
    check(nGap, 4);
    check(nE, 32);
    check(nOe, 36);
    check(nCs, 44);
    check(nLat, 45);
    access(1'b0, 2'd1, 16'h0);
    check(nAb, 2);
    check(nCs, 41);
    check(nOe, 0);
    check(rspRdata, 16'hA5C3);
  endtask

  // ready stretches access; polarity must not change it, async adds a stage
  task automatic s_ready;
    rdyDelay <= 4'd3;
    set_cfg(2'd2, tw(0, 2, 0, 0, 0, 0, 3'b011));
    access(1'b0, 2'd2, 16'h0);
    eSync = nE;
    check(nAb, 3);
    check(rspRdata, 16'hA5C3);
    check(eSync > 1, 1'b1);
    rdyPol <= 1'b0;
    set_cfg(2'd2, tw(0, 2, 0, 0, 0, 0, 3'b001));
    access(1'b0, 2'd2, 16'h0);
    check(nE, eSync);
    rdyPol <= 1'b1;
    set_cfg(2'd2, tw(0, 2, 0, 0, 0, 0, 3'b111));
    access(1'b0, 2'd2, 16'h0);
    check(nE, eSync + 1);
    // idle, last select was cs2
    axi_read(`EBC_OFS_STAT, 32'h4, `EBC_RESP_OKAY);
  endtask

  task automatic s_clock;
    @(negedge clock);
    #1;
    check(bus_reference_clock_out, 1'b0);
    @(posedge clock);
    #1;
    check(bus_reference_clock_out, 1'b1);
    @(posedge clock);
    axi_write(`EBC_OFS_CTRL, 32'h0, `EBC_RESP_OKAY);
    #1;
    check(bus_reference_clock_out, 1'b0);
    @(posedge clock);
    axi_write(`EBC_OFS_CTRL, 32'h1, `EBC_RESP_OKAY);
  endtask

  // clock enable low: request must not be taken, pins stay idle
  task automatic s_freeze;
    ce <= 1'b0;
    reqValid <= 1'b1;
    repeat (3) @(posedge clock);
    check(reqReady, 1'b0);
    check(busCs_n, 4'hF);
    ce <= 1'b1;
    reqValid <= 1'b0;
    @(posedge clock);
    check(busCs_n, 4'hF);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    s_regs();
    s_default();
    s_phases();
    s_ready();
    s_clock();
    s_freeze();
    report_and_stop();
  end
endmodule
`default_nettype wire
